// *** slave_state_machine.sv ***
// Slave state machine: five states gating mailbox, process data and outputs, plus a small parameter directory.
// Assumes all request inputs come from logic on clk_i; physical inputs arrive asynchronously from pins.
`timescale 1ns/1ps
`include "slave_state_defines.svh"

// Overview of operation
// (R1) Power-up enters idle; no traffic allowed
// (R2) Master sets mailbox channels in idle
// (R3) Idle to config checks mailbox setup
// (R4) Config state: mailbox yes, process data no
// (R5) Master sets process-data channels, mapping units
// (R6) Config to held checks channels, clocks
// (R7) Inputs copied before held entry acknowledged
// (R8) Held: both traffic, outputs safe, inputs cyclic (code drives outputs in held while watchdog_en_i is low)
// (R9) Watchdog forces safe outputs unless disabled
// (R10) Master delivers valid outputs before running
// (R11) Running: outputs driven, all traffic allowed
// (R12) Boot entered only from idle state
// (R13) Boot accepts only file-transfer mailbox traffic
// (R14) Slave normally ends up in running
// (R15) Directory entries use index colon subindex
// (R16) Read-only entries ignore writes
// (R17) Directory presented from index 0x1000 up
// (R18) Directory reachable from config state onward
// (R19) Failed check keeps state, flags error
module slave_state_machine #(
  parameter int IN_W  = 16,
  parameter int OUT_W = 16
) (
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  input  wire logic             req_valid_i,
  input  wire logic [3:0]       req_state_i,
  input  wire logic             mbx_cfg_ok_i,
  input  wire logic             pd_cfg_ok_i,
  input  wire logic             dc_used_i,
  input  wire logic             dc_cfg_ok_i,
  input  wire logic             watchdog_en_i,
  input  wire logic [3:0]       mbx_proto_i,
  input  wire logic [IN_W-1:0]  phys_in_i,
  input  wire logic [OUT_W-1:0] pd_out_data_i,
  input  wire logic             dir_req_i,
  input  wire logic             dir_we_i,
  input  wire logic [15:0]      dir_index_i,
  input  wire logic [7:0]       dir_sub_i,
  input  wire logic [31:0]      dir_wdata_i,
  output logic                  ack_o,
  output logic                  err_o,
  output logic [3:0]            state_o,
  output logic                  mbx_allow_o,
  output logic                  file_only_o,
  output logic                  pd_allow_o,
  output logic [OUT_W-1:0]      phys_out_o,
  output logic                  in_copy_o,
  output logic [IN_W-1:0]       dpm_in_o,
  output logic                  dir_rvalid_o,
  output logic                  dir_rerr_o,
  output logic [31:0]           dir_rdata_o
);

  slave_state_pkg::slave_regs_t r;
  slave_state_pkg::slave_regs_t next_r;
  logic [IN_W-1:0]            in_meta;
  logic [IN_W-1:0]            in_sync;
  logic                       held_ok;

  // ----------------------------------------
  // Physical input synchroniser
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      in_meta <= '0;
      in_sync <= '0;
    end else begin
      in_meta <= phys_in_i;
      in_sync <= in_meta;
    end
  end

  // (R6) Channel and clock check
  assign held_ok = pd_cfg_ok_i && (!dc_used_i || dc_cfg_ok_i);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_r            = r;
    next_r.ack        = 1'b0;
    next_r.in_copy    = 1'b0;
    next_r.dir_rvalid = 1'b0;
    next_r.dir_rerr   = 1'b0;
    if (req_valid_i) begin
      next_r.err = 1'b0;
      next_r.ack = 1'b1;
      case (r.st)
        slave_state_pkg::S_IDLE: begin
          if (req_state_i == `ST_CODE_MBXCFG) begin
            // (R3) Mailbox setup check
            if (mbx_cfg_ok_i) begin
              next_r.st = slave_state_pkg::S_MBXCFG;
            end else begin
              // (R19) Stay and flag error
              next_r.err = 1'b1;
            end
          end else if (req_state_i == `ST_CODE_BOOT) begin
            // (R12) Boot from idle with mailbox check
            if (mbx_cfg_ok_i) begin
              next_r.st = slave_state_pkg::S_BOOT;
            end else begin
              next_r.err = 1'b1;
            end
          end else if (req_state_i != `ST_CODE_IDLE) begin
            next_r.err = 1'b1;
          end
        end
        slave_state_pkg::S_MBXCFG: begin
          if (req_state_i == `ST_CODE_HELD) begin
            if (held_ok) begin
              // (R7) Copy inputs before acknowledging
              next_r.st      = slave_state_pkg::S_HELD;
              next_r.in_val  = in_sync;
              next_r.in_copy = 1'b1;
            end else begin
              // (R19) Stay and flag error
              next_r.err = 1'b1;
            end
          end else if (req_state_i == `ST_CODE_IDLE) begin
            next_r.st = slave_state_pkg::S_IDLE;
          end else if (req_state_i != `ST_CODE_MBXCFG) begin
            // (R12) Boot refused outside idle
            next_r.err = 1'b1;
          end
        end
        // (R14) Running kept until the master steps down
        slave_state_pkg::S_HELD, slave_state_pkg::S_RUN: begin
          if (req_state_i == `ST_CODE_RUN) begin
            next_r.st = slave_state_pkg::S_RUN;
          end else if (req_state_i == `ST_CODE_HELD) begin
            next_r.st = slave_state_pkg::S_HELD;
          end else if (req_state_i == `ST_CODE_MBXCFG) begin
            next_r.st = slave_state_pkg::S_MBXCFG;
          end else if (req_state_i == `ST_CODE_IDLE) begin
            next_r.st = slave_state_pkg::S_IDLE;
          end else begin
            next_r.err = 1'b1;
          end
        end
        slave_state_pkg::S_BOOT: begin
          if (req_state_i == `ST_CODE_IDLE) begin
            next_r.st = slave_state_pkg::S_IDLE;
          end else if (req_state_i != `ST_CODE_BOOT) begin
            next_r.err = 1'b1;
          end
        end
        default: begin
          next_r.st = slave_state_pkg::S_IDLE;
        end
      endcase
    end

    // (R8) Cyclic input update in held and running
    if ((r.st == slave_state_pkg::S_HELD || r.st == slave_state_pkg::S_RUN) && !next_r.in_copy) begin
      next_r.in_val = in_sync;
    end

    // Gating from the state being entered
    case (next_r.st)
      slave_state_pkg::S_MBXCFG: begin
        // (R4) Mailbox only
        next_r.state_code = `ST_CODE_MBXCFG;
        next_r.mbx_ok     = 1'b1;
        next_r.pd_ok      = 1'b0;
        next_r.file_only  = 1'b0;
      end
      slave_state_pkg::S_HELD: begin
        next_r.state_code = `ST_CODE_HELD;
        next_r.mbx_ok     = 1'b1;
        next_r.pd_ok      = 1'b1;
        next_r.file_only  = 1'b0;
      end
      slave_state_pkg::S_RUN: begin
        // (R11) All traffic allowed
        next_r.state_code = `ST_CODE_RUN;
        next_r.mbx_ok     = 1'b1;
        next_r.pd_ok      = 1'b1;
        next_r.file_only  = 1'b0;
      end
      slave_state_pkg::S_BOOT: begin
        // (R13) File-transfer mailbox only
        next_r.state_code = `ST_CODE_BOOT;
        next_r.mbx_ok     = (mbx_proto_i == `MBX_PROTO_FILE);
        next_r.pd_ok      = 1'b0;
        next_r.file_only  = 1'b1;
      end
      default: begin
        // (R1) Idle blocks all traffic
        next_r.state_code = `ST_CODE_IDLE;
        next_r.mbx_ok     = 1'b0;
        next_r.pd_ok      = 1'b0;
        next_r.file_only  = 1'b0;
      end
    endcase

    // (R9) Safe outputs unless running or watchdog off in held
    if (next_r.st == slave_state_pkg::S_RUN ||
        (next_r.st == slave_state_pkg::S_HELD && !watchdog_en_i)) begin
      next_r.out_val = pd_out_data_i;
    end else begin
      next_r.out_val = '0;
    end

    // (R18) Directory served from config state onward
    if (dir_req_i) begin
      next_r.dir_rvalid = 1'b1;
      next_r.dir_rdata  = '0;
      if (r.st == slave_state_pkg::S_IDLE || r.st == slave_state_pkg::S_BOOT ||
          dir_index_i < `DIR_FIRST_INDEX) begin
        // (R17) Lower indices not presented
        next_r.dir_rerr = 1'b1;
      end else if (dir_index_i == `DIR_IDX_RESTORE && dir_sub_i == `DIR_SUB_ONE) begin
        // (R15) Index and subindex decode
        if (dir_we_i) begin
          next_r.restore_val = dir_wdata_i;
        end
        next_r.dir_rdata = dir_we_i ? dir_wdata_i : r.restore_val;
      end else if (dir_index_i == `DIR_IDX_DEVTYPE && dir_sub_i == `DIR_SUB_ZERO) begin
        // (R16) Read-only, write refused
        next_r.dir_rerr  = dir_we_i;
        next_r.dir_rdata = `DIR_VAL_DEVTYPE;
      end else if (dir_index_i == `DIR_IDX_IDENT && dir_sub_i == `DIR_SUB_ONE) begin
        next_r.dir_rerr  = dir_we_i;
        next_r.dir_rdata = `DIR_VAL_VENDOR;
      end else if (dir_index_i == `DIR_IDX_IDENT && dir_sub_i == `DIR_SUB_TWO) begin
        next_r.dir_rerr  = dir_we_i;
        next_r.dir_rdata = `DIR_VAL_PRODUCT;
      end else begin
        next_r.dir_rerr = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r <= '{st: slave_state_pkg::S_IDLE, state_code: `ST_CODE_IDLE,
             restore_val: `DIR_RESTORE_RST, default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign ack_o        = r.ack;
  assign err_o        = r.err;
  assign state_o      = r.state_code;
  assign mbx_allow_o  = r.mbx_ok;
  assign file_only_o  = r.file_only;
  assign pd_allow_o   = r.pd_ok;
  assign phys_out_o   = r.out_val;
  assign in_copy_o    = r.in_copy;
  assign dpm_in_o     = r.in_val;
  assign dir_rvalid_o = r.dir_rvalid;
  assign dir_rerr_o   = r.dir_rerr;
  assign dir_rdata_o  = r.dir_rdata;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_idle_no_traffic: assert property (@(posedge clk_i) disable iff (!nrst_i) // (R1)
    state_o == `ST_CODE_IDLE |-> !mbx_allow_o && !pd_allow_o) else $error("traffic allowed in idle");
  chk_mbx_check: assert property (@(posedge clk_i) disable iff (!nrst_i) // (R3)
    req_valid_i && r.st == slave_state_pkg::S_IDLE && req_state_i == `ST_CODE_MBXCFG && !mbx_cfg_ok_i
    |=> state_o == `ST_CODE_IDLE && err_o) else $error("bad mailbox setup accepted");
  chk_config_gating: assert property (@(posedge clk_i) disable iff (!nrst_i) // (R4)
    state_o == `ST_CODE_MBXCFG |-> mbx_allow_o && !pd_allow_o) else $error("config state gating wrong");
  chk_held_check: assert property (@(posedge clk_i) disable iff (!nrst_i) // (R6)
    req_valid_i && r.st == slave_state_pkg::S_MBXCFG && req_state_i == `ST_CODE_HELD && !held_ok
    |=> state_o == `ST_CODE_MBXCFG && err_o) else $error("bad channel setup accepted");
  chk_input_copy: assert property (@(posedge clk_i) disable iff (!nrst_i) // (R7)
    $rose(state_o == `ST_CODE_HELD) && $past(r.st) == slave_state_pkg::S_MBXCFG
    |-> in_copy_o && ack_o && dpm_in_o == $past(in_sync)) else $error("inputs not copied on held entry");
  chk_held_safe: assert property (@(posedge clk_i) disable iff (!nrst_i) // (R9)
    $past(watchdog_en_i) && state_o == `ST_CODE_HELD |-> phys_out_o == '0) else $error("outputs not safe");
  chk_run_outputs: assert property (@(posedge clk_i) disable iff (!nrst_i) // (R11)
    state_o == `ST_CODE_RUN |-> phys_out_o == $past(pd_out_data_i) && pd_allow_o) else $error("run outputs wrong");
  chk_boot_entry: assert property (@(posedge clk_i) disable iff (!nrst_i) // (R12)
    req_valid_i && req_state_i == `ST_CODE_BOOT && r.st != slave_state_pkg::S_IDLE
    && r.st != slave_state_pkg::S_BOOT |=> err_o && state_o != `ST_CODE_BOOT) else $error("boot from non-idle");
  chk_boot_gating: assert property (@(posedge clk_i) disable iff (!nrst_i) // (R13)
    state_o == `ST_CODE_BOOT |-> !pd_allow_o && file_only_o) else $error("boot gating wrong");
  chk_ro_write: assert property (@(posedge clk_i) disable iff (!nrst_i) // (R16)
    dir_req_i && dir_we_i && dir_index_i == `DIR_IDX_IDENT
    |=> dir_rvalid_o && dir_rerr_o) else $error("read-only write accepted");
  chk_low_index: assert property (@(posedge clk_i) disable iff (!nrst_i) // (R17)
    dir_req_i && dir_index_i < `DIR_FIRST_INDEX |=> dir_rerr_o) else $error("low index served");
  chk_dir_idle: assert property (@(posedge clk_i) disable iff (!nrst_i) // (R18)
    dir_req_i && r.st == slave_state_pkg::S_IDLE |=> dir_rerr_o) else $error("directory served in idle");

endmodule

// *** slave_state_defines.svh ***
// Constants of the slave state machine: state codes, parameter directory layout, identity values.
// Assumes inclusion by its bare name from the design.
`ifndef SLAVE_STATE_DEFINES_SVH
`define SLAVE_STATE_DEFINES_SVH

// Requested/reported state codes
`define ST_CODE_IDLE     4'h1
`define ST_CODE_MBXCFG   4'h2
`define ST_CODE_BOOT     4'h3
`define ST_CODE_HELD     4'h4
`define ST_CODE_RUN      4'h8

// Parameter directory
`define DIR_FIRST_INDEX  16'h1000
`define DIR_IDX_DEVTYPE  16'h1000
`define DIR_IDX_IDENT    16'h1018
`define DIR_IDX_RESTORE  16'h1011
`define DIR_SUB_ONE      8'h01
`define DIR_SUB_TWO      8'h02
`define DIR_SUB_ZERO     8'h00
// Arbitrary neutral identity values
`define DIR_VAL_DEVTYPE  32'h00000ABC
`define DIR_VAL_VENDOR   32'h00000055
`define DIR_VAL_PRODUCT  32'h00000077
`define DIR_RESTORE_RST  32'h00000000

// Mailbox protocol code of file-transfer traffic
`define MBX_PROTO_FILE   4'h4

`endif

// *** slave_state_pkg.sv ***
// Types of the slave state machine.
// Assumes the defines header is compiled alongside.
package slave_state_pkg;

  typedef enum logic [2:0] {
    S_IDLE,
    S_MBXCFG,
    S_HELD,
    S_RUN,
    S_BOOT
  } slave_state_t;

  typedef struct packed {
    slave_state_t st;
    logic        ack;
    logic        err;
    logic [3:0]  state_code;
    logic        mbx_ok;
    logic        pd_ok;
    logic        file_only;
    logic [15:0] out_val;
    logic        in_copy;
    logic [15:0] in_val;
    logic        dir_rvalid;
    logic        dir_rerr;
    logic [31:0] dir_rdata;
    logic [31:0] restore_val;
  } slave_regs_t;

endpackage

// *** master_model.sv ***
// Network master model: state requests, directory accesses, output data.
// Assumes the slave answers each request at the edge that takes it, read at the next negedge.
`timescale 1ns/1ps
module master_model (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic        err_i,
  input  wire logic [3:0]  state_i,
  input  wire logic        dir_rvalid_i,
  input  wire logic        dir_rerr_i,
  input  wire logic [31:0] dir_rdata_i,
  output logic             req_valid_o,
  output logic [3:0]       req_state_o,
  output logic [15:0]      pd_out_data_o,
  output logic             dir_req_o,
  output logic             dir_we_o,
  output logic [15:0]      dir_index_o,
  output logic [7:0]       dir_sub_o,
  output logic [31:0]      dir_wdata_o
);
  initial begin
    {req_valid_o, req_state_o, pd_out_data_o} = '0;
    {dir_req_o, dir_we_o, dir_index_o, dir_sub_o, dir_wdata_o} = '0;
  end

  // boot asked from idle by t_boot and from held by t_climb, where it must be refused
  task automatic request(input logic [3:0] code, output logic a, output logic [3:0] s, output logic e);
    @(negedge clk_i);
    req_valid_o = 1'b1;
    req_state_o = code;
    @(negedge clk_i);
    a = ack_i;
    s = state_i;
    e = err_i;
    req_valid_o = 1'b0;
    req_state_o = ~code;
  endtask

  task automatic set_outputs(input logic [15:0] d);
    @(negedge clk_i);
    pd_out_data_o = d;
  endtask

  // Released lines show the inverse of their last value
  task automatic dir_access(input logic we, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd,
                            output logic v, output logic re, output logic [31:0] rd);
    @(negedge clk_i);
    {dir_req_o, dir_we_o, dir_index_o, dir_sub_o, dir_wdata_o} = {1'b1, we, idx, sub, wd};
    @(negedge clk_i);
    {v, re, rd} = {dir_rvalid_i, dir_rerr_i, dir_rdata_i};
    {dir_req_o, dir_we_o, dir_index_o, dir_sub_o, dir_wdata_o} = {1'b0, ~we, ~idx, ~sub, ~wd};
  endtask
endmodule

// *** slave_state_machine_test.sv ***
// Self-checking bench of the slave state machine, driven through the master model.
// Assumes the design and master model files are compiled first.
`timescale 1ns/1ps
module slave_state_machine_test;
  logic clk_i = 1'b0, nrst_i = 1'b0;
  logic mbx_cfg_ok_i = 1'b0, pd_cfg_ok_i = 1'b0, dc_used_i = 1'b0, dc_cfg_ok_i = 1'b0, watchdog_en_i = 1'b1;
  logic [3:0] mbx_proto_i = 4'h0;
  logic [15:0] phys_in_i = 16'hA5C3;
  logic req_valid_i, dir_req_i, dir_we_i, ack_o, err_o, mbx_allow_o, file_only_o, pd_allow_o;
  logic in_copy_o, dir_rvalid_o, dir_rerr_o;
  logic [3:0] req_state_i, state_o;
  logic [15:0] pd_out_data_i, phys_out_o, dpm_in_o, dir_index_i;
  logic [7:0] dir_sub_i;
  logic [31:0] dir_wdata_i, dir_rdata_o;
  int errors = 0, total_checks = 0;

  always #10 clk_i = ~clk_i;

  slave_state_machine DUT (.clk_i(clk_i), .nrst_i(nrst_i), .req_valid_i(req_valid_i), .req_state_i(req_state_i),
    .mbx_cfg_ok_i(mbx_cfg_ok_i), .pd_cfg_ok_i(pd_cfg_ok_i), .dc_used_i(dc_used_i), .dc_cfg_ok_i(dc_cfg_ok_i),
    .watchdog_en_i(watchdog_en_i), .mbx_proto_i(mbx_proto_i), .phys_in_i(phys_in_i),
    .pd_out_data_i(pd_out_data_i), .dir_req_i(dir_req_i), .dir_we_i(dir_we_i), .dir_index_i(dir_index_i),
    .dir_sub_i(dir_sub_i), .dir_wdata_i(dir_wdata_i), .ack_o(ack_o), .err_o(err_o), .state_o(state_o),
    .mbx_allow_o(mbx_allow_o), .file_only_o(file_only_o), .pd_allow_o(pd_allow_o), .phys_out_o(phys_out_o),
    .in_copy_o(in_copy_o), .dpm_in_o(dpm_in_o), .dir_rvalid_o(dir_rvalid_o), .dir_rerr_o(dir_rerr_o),
    .dir_rdata_o(dir_rdata_o));

  master_model master (.clk_i(clk_i), .ack_i(ack_o), .err_i(err_o), .state_i(state_o),
    .dir_rvalid_i(dir_rvalid_o), .dir_rerr_i(dir_rerr_o), .dir_rdata_i(dir_rdata_o), .req_valid_o(req_valid_i),
    .req_state_o(req_state_i), .pd_out_data_o(pd_out_data_i), .dir_req_o(dir_req_i), .dir_we_o(dir_we_i),
    .dir_index_o(dir_index_i), .dir_sub_o(dir_sub_i), .dir_wdata_o(dir_wdata_i));

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic req(input logic [3:0] code, input logic [3:0] exp_st, input logic exp_err);
    logic a, e;
    logic [3:0] s;
    master.request(code, a, s, e);
    check("ack", 32'(a), 32'h1);
    check("state", 32'(s), 32'(exp_st));
    check("err", 32'(e), 32'(exp_err));
  endtask

  task automatic dir(input logic we, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd,
                     input logic exp_err, input logic [31:0] exp_d);
    logic v, re;
    logic [31:0] rd;
    master.dir_access(we, idx, sub, wd, v, re, rd);
    check("dir_rvalid", 32'(v), 32'h1);
    check("dir_rerr", 32'(re), 32'(exp_err));
    if (!exp_err) check("dir_rdata", rd, exp_d);
  endtask

  task automatic t_reset;
    check("state idle", 32'(state_o), 32'h1);
    check("gates", {29'h0, mbx_allow_o, pd_allow_o, phys_out_o != 16'h0}, 32'h0);
    dir(1'b0, 16'h1018, 8'h01, 32'h0, 1'b1, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_boot;
    req(4'h3, 4'h1, 1'b1);
    mbx_cfg_ok_i = 1'b1;
    req(4'h3, 4'h3, 1'b0);
    check("boot gates", {30'h0, file_only_o, pd_allow_o}, 32'h2);
    mbx_proto_i = 4'h4;
    repeat (2) @(negedge clk_i);
    check("file mbx", 32'(mbx_allow_o), 32'h1);
    mbx_proto_i = 4'h1;
    repeat (2) @(negedge clk_i);
    check("other mbx", 32'(mbx_allow_o), 32'h0);
    req(4'h2, 4'h3, 1'b1);
    req(4'h1, 4'h1, 1'b0);
    $display("test boot done");
  endtask

  task automatic t_climb;
    int n;
    mbx_cfg_ok_i = 1'b0;
    req(4'h2, 4'h1, 1'b1);
    mbx_cfg_ok_i = 1'b1;
    req(4'h2, 4'h2, 1'b0);
    check("cfg gates", {30'h0, mbx_allow_o, pd_allow_o}, 32'h2);
    dir(1'b0, 16'h1018, 8'h01, 32'h0, 1'b0, 32'h00000055);
    dir(1'b0, 16'h0FFF, 8'h00, 32'h0, 1'b1, 32'h0);
    dir(1'b1, 16'h1018, 8'h02, 32'h12345678, 1'b1, 32'h0);
    dir(1'b0, 16'h1018, 8'h02, 32'h0, 1'b0, 32'h00000077);
    dir(1'b1, 16'h1011, 8'h01, 32'h0000BEEF, 1'b0, 32'h0000BEEF);
    dir(1'b0, 16'h1011, 8'h01, 32'h0, 1'b0, 32'h0000BEEF);
    req(4'h4, 4'h2, 1'b1);
    pd_cfg_ok_i = 1'b1;
    dc_used_i = 1'b1;
    req(4'h4, 4'h2, 1'b1);
    dc_cfg_ok_i = 1'b1;
    req(4'h4, 4'h4, 1'b0);
    check("in copy", 32'(in_copy_o), 32'h1);
    check("in image", 32'(dpm_in_o), 32'hA5C3);
    check("held gates", {30'h0, mbx_allow_o, pd_allow_o}, 32'h3);
    master.set_outputs(16'h3C5A);
    repeat (2) @(negedge clk_i);
    check("safe out", 32'(phys_out_o), 32'h0);
    watchdog_en_i = 1'b0;
    repeat (2) @(negedge clk_i);
    check("wd off out", 32'(phys_out_o), 32'h3C5A);
    watchdog_en_i = 1'b1;
    phys_in_i = 16'h0F1E;
    n = 0;
    while (dpm_in_o !== 16'h0F1E && n < 8) begin
      @(negedge clk_i);
      n++;
    end
    if (n == 8) wrap_up_fail();
    check("cyclic in", 32'(dpm_in_o), 32'h0F1E);
    req(4'h3, 4'h4, 1'b1);
    req(4'h8, 4'h8, 1'b0);
    master.set_outputs(16'h9E01);
    repeat (2) @(negedge clk_i);
    check("run out", 32'(phys_out_o), 32'h9E01);
    check("run gates", {30'h0, mbx_allow_o, pd_allow_o}, 32'h3);
    repeat (4) @(negedge clk_i);
    check("stays run", 32'(state_o), 32'h8);
    req(4'h1, 4'h1, 1'b0);
    check("idle out", 32'(phys_out_o), 32'h0);
    $display("test climb done");
  endtask

  task automatic wrap_up_fail;
    errors++;
    wrap_up();
  endtask

  initial begin
    #1000000;
    wrap_up_fail();
  end

  initial begin
    repeat (12) @(negedge clk_i);
    nrst_i = 1'b1;
    @(negedge clk_i);
    t_reset();
    t_boot();
    t_climb();
    wrap_up();
  end
endmodule
